// ===== logic/fdiv_defs.vh
`ifndef FDIV_DEFS_VH
`define FDIV_DEFS_VH
// Operation codes presented on op_in
`define FDIV_OP_NOP 4'h0
`define FDIV_OP_SIGN_S32 4'h1
`define FDIV_OP_SIGN_U32 4'h2
`define FDIV_OP_SIGN_S64_32 4'h3
`define FDIV_OP_SIGN_U64_32 4'h4
`define FDIV_OP_SIGN_S64 4'h5
`define FDIV_OP_SIGN_U64 4'h6
`define FDIV_OP_SUBC_32 4'h7
`define FDIV_OP_SUBC_64 4'h8
`define FDIV_OP_FIX_32 4'h9
`define FDIV_OP_FIX_64 4'hA
`define FDIV_OP_SIGN_S16 4'hB
`define FDIV_OP_SIGN_U16 4'hC
`define FDIV_OP_WRITE 4'hD
// Division flavours for the sign-assignment step
`define FDIV_FL_TRUNC 2'h0
`define FDIV_FL_FLOOR 2'h1
`define FDIV_FL_EUCLID 2'h2
// Register bank indices
`define FDIV_R_NUM_LO 3'h0
`define FDIV_R_NUM 3'h1
`define FDIV_R_REM 3'h2
`define FDIV_R_DEN 3'h3
`define FDIV_R_REM_LO 3'h4
`define FDIV_R_DEN_LO 3'h5
// Bank size and conditional-subtract iterations per cycle
`define FDIV_NREGS 6
`define FDIV_STEPS_32 4
`define FDIV_STEPS_64 2
`define FDIV_RESET_WORD 32'h00000000
`endif

// ===== logic/fdiv_unit.v
// How it works
// RULE1: every operation finishes in one clock; result usable next cycle.
// RULE2: host pipeline untouched; unit only acts on its own op code.
// RULE3: six-word register bank, each word both source and destination.
// RULE4: truncated, floored and euclidean flavours chosen at sign assignment.
// RULE5: 16, 32 and 64-bit signed or unsigned operands, mixed widths allowed.
// RULE6: sign taken from bit matching operand type and width; the code also takes the numerator sign for unsigned ops, from bit 31 or bit 63.
// RULE7: sign preparation stores quotient and remainder sign flags for later.
// RULE8: sign preparation turns numerator and denominator into magnitudes.
// RULE9: conditional subtract runs several restoring iterations per cycle.
// RULE10: sign assignment uses flavour plus saved flags.
// RULE11: sign assignment corrects quotient and remainder for floor or euclid.
// RULE12: all state sits in registers so interrupts may fall between steps.
// RULE13: signed prepare sets negative flag from numerator sign, test from xor.
// RULE14: overflow flag latched when operand is the most negative value.
// RULE15: prepare clears remainder and negates operands with sign set; the code clears the low remainder word only for S64 and U64 ops.
// RULE16: each iteration shifts, compares, subtracts and records quotient bit.
`include "fdiv_defs.vh"
`default_nettype none
module fdiv_unit #(
    parameter STEPS_32 = `FDIV_STEPS_32,
    parameter STEPS_64 = `FDIV_STEPS_64
) (
    // Clock and reset
    input wire clock_in,
    input wire reset_in,
    // Operation from host issue stage
    input wire [3:0] op_in,
    input wire [1:0] flavour_in,
    input wire [2:0] write_sel_in,
    input wire [31:0] write_data_in,
    // Bank and flags
    output reg [191:0] bank_out,
    output reg negative_integer_flag_out,
    output reg quotient_sign_test_flag_out,
    output reg latched_overflow_flag_out,
    output reg denominator_sign_out
);
    reg [31:0] bank [0:`FDIV_NREGS-1];
    reg negative_integer_flag;
    reg quotient_sign_test_flag;
    reg latched_overflow_flag;
    reg den_neg;
    reg [31:0] next_bank [0:`FDIV_NREGS-1];
    reg next_neg;
    reg next_test;
    reg next_ovf;
    reg next_den_neg;
    reg [63:0] num;
    reg [63:0] den;
    reg [63:0] rem;
    reg [64:0] trial;
    reg num_s;
    reg den_s;
    reg q_neg;
    reg r_neg;
    reg adj;
    reg [63:0] mask;
    integer i;

    // Sign bit of a value for a given width code: 0=16, 1=32, 2=64
    function sign_of;
        input [63:0] v;
        input [1:0] w;
        begin
            case (w)
                2'h0: sign_of = v[15];
                2'h1: sign_of = v[31];
                default: sign_of = v[63];
            endcase
        end
    endfunction

    // Most negative value test at a width
    function is_min;
        input [63:0] v;
        input [1:0] w;
        begin
            case (w)
                2'h0: is_min = (v[15:0] == 16'h8000);
                2'h1: is_min = (v[31:0] == 32'h80000000);
                default: is_min = (v == 64'h8000000000000000);
            endcase
        end
    endfunction

    // Prepare one operand: negates the value sign-extended by width when sgn is set, else returns v unchanged
    function [63:0] magnitude;
        input [63:0] v;
        input [1:0] w;
        input sgn;
        reg [63:0] ext;
        begin
            case (w)
                2'h0: ext = {{48{v[15]}}, v[15:0]};
                2'h1: ext = {{32{v[31]}}, v[31:0]};
                default: ext = v;
            endcase
            magnitude = sgn ? (64'h0 - ext) : v;
        end
    endfunction

    always @*
    begin
        for (i = 0; i < `FDIV_NREGS; i = i + 1)
            next_bank[i] = bank[i];
        next_neg = negative_integer_flag;
        next_test = quotient_sign_test_flag;
        next_ovf = latched_overflow_flag;
        next_den_neg = den_neg;
        num = {bank[`FDIV_R_NUM], bank[`FDIV_R_NUM_LO]};
        den = {bank[`FDIV_R_DEN], bank[`FDIV_R_DEN_LO]};
        rem = {bank[`FDIV_R_REM], bank[`FDIV_R_REM_LO]};
        trial = 65'h0;
        num_s = 1'b0;
        den_s = 1'b0;
        q_neg = 1'b0;
        r_neg = 1'b0;
        adj = 1'b0;
        mask = 64'h0;
        case (op_in)
            `FDIV_OP_WRITE:
            begin
                if (write_sel_in < `FDIV_NREGS)
                    next_bank[write_sel_in] = write_data_in;
            end
            // RULE6 width-driven sign
            `FDIV_OP_SIGN_S16, `FDIV_OP_SIGN_U16, `FDIV_OP_SIGN_S32, `FDIV_OP_SIGN_U32:
            begin
                // Narrow forms live in the high words only; the low words are not operands
                num = {32'h0, bank[`FDIV_R_NUM]};
                den = {32'h0, bank[`FDIV_R_DEN]};
                num_s = (op_in == `FDIV_OP_SIGN_S16) ? sign_of(num, 2'h0) : num[31];
                den_s = (op_in == `FDIV_OP_SIGN_S16) ? sign_of(den, 2'h0) :
                        (op_in == `FDIV_OP_SIGN_S32) ? den[31] : 1'b0;
                // RULE13 negative and test flags
                next_neg = num_s;
                next_test = num_s ^ den_s;
                next_den_neg = den_s;
                // RULE14 most negative latches
                if (op_in == `FDIV_OP_SIGN_S16)
                begin
                    if (is_min(num, 2'h0) || is_min(den, 2'h0))
                        next_ovf = 1'b1;
                end
                else if (is_min(num, 2'h1) ||
                         ((op_in == `FDIV_OP_SIGN_S32) && is_min(den, 2'h1)))
                    next_ovf = 1'b1;
                // RULE15 clear remainder, negate
                next_bank[`FDIV_R_REM] = `FDIV_RESET_WORD;
                // RULE8 magnitudes only
                mask = magnitude(num, (op_in == `FDIV_OP_SIGN_S16) ? 2'h0 : 2'h1, num_s);
                next_bank[`FDIV_R_NUM] = mask[31:0];
                mask = magnitude(den, (op_in == `FDIV_OP_SIGN_S16) ? 2'h0 : 2'h1, den_s);
                next_bank[`FDIV_R_DEN] = mask[31:0];
            end
            // RULE5 64-bit numerator forms
            `FDIV_OP_SIGN_S64_32, `FDIV_OP_SIGN_U64_32, `FDIV_OP_SIGN_S64, `FDIV_OP_SIGN_U64:
            begin
                num_s = num[63];
                den_s = (op_in == `FDIV_OP_SIGN_S64_32) ? den[63] :
                        (op_in == `FDIV_OP_SIGN_S64) ? den[63] : 1'b0;
                // RULE7 saved sign flags
                next_neg = num_s;
                next_test = num_s ^ den_s;
                next_den_neg = den_s;
                // RULE14 most negative latches
                if (is_min(num, 2'h2) ||
                    ((op_in == `FDIV_OP_SIGN_S64_32) &&
                     is_min({32'h0, bank[`FDIV_R_DEN]}, 2'h1)) ||
                    ((op_in == `FDIV_OP_SIGN_S64) && is_min(den, 2'h2)))
                    next_ovf = 1'b1;
                // RULE15 clear remainder, negate
                next_bank[`FDIV_R_REM] = `FDIV_RESET_WORD;
                if ((op_in == `FDIV_OP_SIGN_S64) || (op_in == `FDIV_OP_SIGN_U64))
                    next_bank[`FDIV_R_REM_LO] = `FDIV_RESET_WORD;
                mask = magnitude(num, 2'h2, num_s);
                next_bank[`FDIV_R_NUM] = mask[63:32];
                next_bank[`FDIV_R_NUM_LO] = mask[31:0];
                if ((op_in == `FDIV_OP_SIGN_S64) || (op_in == `FDIV_OP_SIGN_U64))
                begin
                    mask = magnitude(den, 2'h2, den_s);
                    next_bank[`FDIV_R_DEN] = mask[63:32];
                    next_bank[`FDIV_R_DEN_LO] = mask[31:0];
                end
                else
                begin
                    // Denominator is the single high word here
                    mask = magnitude({32'h0, bank[`FDIV_R_DEN]}, 2'h1, den_s);
                    next_bank[`FDIV_R_DEN] = mask[31:0];
                end
            end
            // RULE9 several iterations per cycle
            `FDIV_OP_SUBC_32:
            begin
                num = {32'h0, bank[`FDIV_R_NUM]};
                rem = {32'h0, bank[`FDIV_R_REM]};
                for (i = 0; i < STEPS_32; i = i + 1)
                begin
                    // RULE16 shift compare subtract
                    trial = {rem[63:0], num[31]};
                    num = {32'h0, num[30:0], 1'b0};
                    if (trial >= {33'h0, bank[`FDIV_R_DEN]})
                    begin
                        trial = trial - {33'h0, bank[`FDIV_R_DEN]};
                        num[0] = 1'b1;
                    end
                    rem = trial[63:0];
                end
                next_bank[`FDIV_R_NUM] = num[31:0];
                next_bank[`FDIV_R_REM] = rem[31:0];
            end
            `FDIV_OP_SUBC_64:
            begin
                for (i = 0; i < STEPS_64; i = i + 1)
                begin
                    // RULE16 shift compare subtract
                    trial = {rem, num[63]};
                    num = {num[62:0], 1'b0};
                    if (trial >= {1'b0, den})
                    begin
                        trial = trial - {1'b0, den};
                        num[0] = 1'b1;
                    end
                    rem = trial[63:0];
                end
                next_bank[`FDIV_R_NUM] = num[63:32];
                next_bank[`FDIV_R_NUM_LO] = num[31:0];
                next_bank[`FDIV_R_REM] = rem[63:32];
                next_bank[`FDIV_R_REM_LO] = rem[31:0];
            end
            // RULE10 flavour and flags set signs
            `FDIV_OP_FIX_32, `FDIV_OP_FIX_64:
            begin
                mask = (op_in == `FDIV_OP_FIX_32) ? 64'h00000000FFFFFFFF : 64'hFFFFFFFFFFFFFFFF;
                if (op_in == `FDIV_OP_FIX_32)
                begin
                    num = {32'h0, bank[`FDIV_R_NUM]};
                    rem = {32'h0, bank[`FDIV_R_REM]};
                    den = {32'h0, bank[`FDIV_R_DEN]};
                end
                // RULE4 flavour selection
                // RULE11 floor and euclid adjust
                adj = (rem != 64'h0) &&
                      (((flavour_in == `FDIV_FL_FLOOR) && quotient_sign_test_flag) ||
                       ((flavour_in == `FDIV_FL_EUCLID) && negative_integer_flag));
                if (adj)
                begin
                    num = num + 64'h1;
                    rem = den - rem;
                end
                q_neg = quotient_sign_test_flag;
                r_neg = (flavour_in == `FDIV_FL_TRUNC) ? negative_integer_flag :
                        (flavour_in == `FDIV_FL_FLOOR) ? den_neg : 1'b0;
                if (q_neg)
                    num = 64'h0 - num;
                if (r_neg)
                    rem = 64'h0 - rem;
                num = num & mask;
                rem = rem & mask;
                next_bank[`FDIV_R_NUM] = (op_in == `FDIV_OP_FIX_32) ? num[31:0] : num[63:32];
                next_bank[`FDIV_R_REM] = (op_in == `FDIV_OP_FIX_32) ? rem[31:0] : rem[63:32];
                if (op_in == `FDIV_OP_FIX_64)
                begin
                    next_bank[`FDIV_R_NUM_LO] = num[31:0];
                    next_bank[`FDIV_R_REM_LO] = rem[31:0];
                end
            end
            // RULE2 other codes leave all state alone
            default:
            begin
                next_neg = negative_integer_flag;
            end
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < `FDIV_NREGS; g = g + 1)
        begin : gen_bank
            // RULE3 six-word bank
            always @(posedge clock_in)
            begin
                if (reset_in)
                    bank[g] <= `FDIV_RESET_WORD;
                else
                    bank[g] <= next_bank[g];
            end
        end
    endgenerate

    // RULE1 single-cycle commit
    // RULE12 all state held in flops
    always @(posedge clock_in)
    begin
        if (reset_in)
        begin
            negative_integer_flag <= 1'b0;
            quotient_sign_test_flag <= 1'b0;
            latched_overflow_flag <= 1'b0;
            den_neg <= 1'b0;
            bank_out <= 192'h0;
            negative_integer_flag_out <= 1'b0;
            quotient_sign_test_flag_out <= 1'b0;
            latched_overflow_flag_out <= 1'b0;
            denominator_sign_out <= 1'b0;
        end
        else
        begin
            negative_integer_flag <= next_neg;
            quotient_sign_test_flag <= next_test;
            latched_overflow_flag <= next_ovf;
            den_neg <= next_den_neg;
            bank_out <= {next_bank[5], next_bank[4], next_bank[3],
                         next_bank[2], next_bank[1], next_bank[0]};
            negative_integer_flag_out <= next_neg;
            quotient_sign_test_flag_out <= next_test;
            latched_overflow_flag_out <= next_ovf;
            denominator_sign_out <= next_den_neg;
        end
    end
endmodule
`default_nettype wire

// ===== tb/fdiv_unit_props.sv
`include "fdiv_defs.vh"
`default_nettype none
module fdiv_unit_props #(
    parameter STEPS_32 = `FDIV_STEPS_32,
    parameter STEPS_64 = `FDIV_STEPS_64
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Operation
    input wire logic [3:0] op_in,
    input wire logic [1:0] flavour_in,
    input wire logic [2:0] write_sel_in,
    input wire logic [31:0] write_data_in,
    // Bank and flags
    input wire logic [191:0] bank_out,
    input wire logic negative_integer_flag_out,
    input wire logic quotient_sign_test_flag_out,
    input wire logic latched_overflow_flag_out,
    input wire logic denominator_sign_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    reset_clear_a: assert property ($fell(reset_in) |-> bank_out == 192'h0
        && !latched_overflow_flag_out) else $error("bank not clear after reset");
    write_bank_a: assert property (op_in == `FDIV_OP_WRITE && write_sel_in < 3'h6
        |=> bank_out[$past(write_sel_in) * 32 +: 32] == $past(write_data_in))
        else $error("bank write lost");
    nop_hold_a: assert property (op_in == `FDIV_OP_NOP |=> $stable(bank_out))
        else $error("bank changed on idle op");
    neg_flag_a: assert property (op_in == `FDIV_OP_SIGN_S32
        |=> negative_integer_flag_out == $past(bank_out[63])) else $error("negative flag wrong");
    test_flag_a: assert property (op_in == `FDIV_OP_SIGN_S32
        |=> quotient_sign_test_flag_out == $past(bank_out[63] ^ bank_out[127]))
        else $error("test flag wrong");
    rem_clear_a: assert property (op_in == `FDIV_OP_SIGN_S32 |=> bank_out[95:64] == 32'h0)
        else $error("remainder not cleared");
    num_mag_a: assert property (op_in == `FDIV_OP_SIGN_S32 |=> bank_out[63:32] ==
        ($past(bank_out[63]) ? -$past(bank_out[63:32]) : $past(bank_out[63:32])))
        else $error("numerator magnitude wrong");
    ovf_set_a: assert property (op_in == `FDIV_OP_SIGN_S32 && (bank_out[63:32] == 32'h8000_0000
        || bank_out[127:96] == 32'h8000_0000) |=> latched_overflow_flag_out)
        else $error("overflow not flagged");
    ovf_sticky_a: assert property (latched_overflow_flag_out |=> latched_overflow_flag_out)
        else $error("overflow flag dropped");
    half_sign_a: assert property (op_in == `FDIV_OP_SIGN_S16
        |=> negative_integer_flag_out == $past(bank_out[47])) else $error("16-bit sign wrong");
endmodule
bind fdiv_unit fdiv_unit_props #(.STEPS_32(STEPS_32), .STEPS_64(STEPS_64)) u_props (.*);
`default_nettype wire

// ===== tb/fdiv_host_model.sv
`include "fdiv_defs.vh"
`default_nettype none
module fdiv_host_model (
    // Clock
    input wire logic clock_in,
    // Issued operation
    output logic [3:0] op_out,
    output logic [1:0] flavour_out,
    output logic [2:0] write_sel_out,
    output logic [31:0] write_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        op_out = `FDIV_OP_NOP;
        flavour_out = 2'h0;
        write_sel_out = 3'h0;
        write_data_out = 32'h0;
    end
    // Back to back issue, one op per edge, as a pipeline would
    task issue(input logic [3:0] op, input logic [1:0] fl, input logic [2:0] sel,
        input logic [31:0] data);
        @(posedge clock_in);
        op_out <= op;
        flavour_out <= fl;
        write_sel_out <= sel;
        write_data_out <= data;
    endtask
    // Idle the unit and let the last result land; data lines scrambled
    task settle();
        @(posedge clock_in);
        op_out <= `FDIV_OP_NOP;
        write_data_out <= ~write_data_out;
        @(negedge clock_in);
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_fast_integer_division_unit.sv
`include "fdiv_defs.vh"
`default_nettype none
module tb_fast_integer_division_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic [3:0] op;
    logic [1:0] flavour;
    logic [2:0] sel;
    logic [31:0] data;
    logic [191:0] bank_out;
    logic neg, test, ovf, den_sign;
    int err_total = 0;
    int n_tests = 0;
    initial
    begin
        forever #25 clock_in = ~clock_in;
    end
    fdiv_host_model u_host (.clock_in(clock_in), .op_out(op), .flavour_out(flavour),
        .write_sel_out(sel), .write_data_out(data));
    fdiv_unit u_dut (.clock_in(clock_in), .reset_in(reset_in), .op_in(op), .flavour_in(flavour),
        .write_sel_in(sel), .write_data_in(data), .bank_out(bank_out),
        .negative_integer_flag_out(neg), .quotient_sign_test_flag_out(test),
        .latched_overflow_flag_out(ovf), .denominator_sign_out(den_sign));
    function automatic logic [31:0] word(input int k);
        return bank_out[32 * k +: 32];
    endfunction
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [2:0] s, input logic [31:0] d);
        u_host.issue(`FDIV_OP_WRITE, 2'h0, s, d);
    endtask
    task t_write();
        for (int k = 0; k < 8; k++) wr(3'(k), 32'hA5A5_0000 + 32'(k));
        u_host.settle();
        for (int k = 0; k < 6; k++) chk({32'h0, word(k)}, {32'h0, 32'hA5A5_0000 + 32'(k)});
    endtask
    task t_div32(input logic signed [31:0] n, input logic signed [31:0] d, input logic [1:0] fl);
        logic signed [31:0] q;
        logic signed [31:0] r;
        wr(`FDIV_R_NUM, n);
        wr(`FDIV_R_DEN, d);
        u_host.issue(`FDIV_OP_SIGN_S32, fl, 3'h0, 32'h0);
        u_host.settle();
        chk({32'h0, word(1)}, {32'h0, (n < 0) ? -n : n});
        chk({32'h0, word(2)}, 64'h0);
        chk({63'h0, neg}, {63'h0, n < 0});
        chk({63'h0, test}, {63'h0, (n < 0) ^ (d < 0)});
        chk({63'h0, den_sign}, {63'h0, d < 0});
        repeat (8) u_host.issue(`FDIV_OP_SUBC_32, fl, 3'h0, 32'h0);
        u_host.issue(`FDIV_OP_FIX_32, fl, 3'h0, 32'h0);
        u_host.settle();
        q = n / d;
        r = n % d;
        if (r != 0 && fl == `FDIV_FL_FLOOR && ((n < 0) != (d < 0)))
        begin
            q = q - 1;
            r = r + d;
        end
        if (r < 0 && fl == `FDIV_FL_EUCLID)
        begin
            q = (d > 0) ? q - 1 : q + 1;
            r = (d > 0) ? r + d : r - d;
        end
        chk({32'h0, word(1)}, {32'h0, q});
        chk({32'h0, word(2)}, {32'h0, r});
    endtask
    task t_div64(input logic [63:0] n, input logic [63:0] d);
        wr(`FDIV_R_NUM_LO, n[31:0]);
        wr(`FDIV_R_NUM, n[63:32]);
        wr(`FDIV_R_DEN, d[63:32]);
        wr(`FDIV_R_DEN_LO, d[31:0]);
        u_host.issue(`FDIV_OP_SIGN_U64, 2'h0, 3'h0, 32'h0);
        repeat (16) u_host.issue(`FDIV_OP_SUBC_64, 2'h0, 3'h0, 32'h0);
        u_host.settle();
        repeat (16) u_host.issue(`FDIV_OP_SUBC_64, 2'h0, 3'h0, 32'h0);
        u_host.issue(`FDIV_OP_FIX_64, `FDIV_FL_TRUNC, 3'h0, 32'h0);
        u_host.settle();
        chk({word(1), word(0)}, n / d);
        chk({word(2), word(4)}, n % d);
    endtask
    task t_prep(input logic [3:0] op, input logic [63:0] n, input logic [63:0] d,
        input logic [63:0] qn, input logic [63:0] qd, input logic tf);
        wr(`FDIV_R_NUM_LO, n[31:0]);
        wr(`FDIV_R_NUM, n[63:32]);
        wr(`FDIV_R_DEN, d[63:32]);
        wr(`FDIV_R_DEN_LO, d[31:0]);
        wr(`FDIV_R_REM, 32'h1234_5678);
        u_host.issue(op, 2'h0, 3'h0, 32'h0);
        u_host.settle();
        chk({word(1), word(0)}, qn);
        chk({word(3), word(5)}, qd);
        chk({63'h0, test}, {63'h0, tf});
        chk({32'h0, word(2)}, 64'h0);
    endtask
    task t_ovf();
        wr(`FDIV_R_NUM, 32'h8000_0000);
        wr(`FDIV_R_DEN, 32'h0000_0001);
        u_host.issue(`FDIV_OP_SIGN_S32, 2'h0, 3'h0, 32'h0);
        u_host.settle();
        chk({63'h0, ovf}, 64'h1);
        wr(`FDIV_R_NUM, 32'h0000_0005);
        u_host.issue(`FDIV_OP_SIGN_S32, 2'h0, 3'h0, 32'h0);
        u_host.settle();
        chk({63'h0, ovf}, 64'h1);
        @(posedge clock_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        reset_in <= 1'b0;
        @(negedge clock_in);
        chk({63'h0, ovf}, 64'h0);
        chk({word(1), word(2)}, 64'h0);
    endtask
    task t_s16();
        wr(`FDIV_R_NUM, 32'hFFFF_FFFB);
        wr(`FDIV_R_DEN, 32'h0000_0003);
        u_host.issue(`FDIV_OP_SIGN_S16, 2'h0, 3'h0, 32'h0);
        u_host.settle();
        chk({63'h0, neg}, 64'h1);
        chk({32'h0, word(1)}, 64'h5);
    endtask
    task finish_test();
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        logic [31:0] ns [5] = '{32'hFFFF_FFF9, 32'h7, 32'hFFFF_FFF9, 32'h7, 32'h7FFF_FFFF};
        logic [31:0] ds [5] = '{32'h2, 32'hFFFF_FFFE, 32'hFFFF_FFFE, 32'h2, 32'h3};
        repeat (20) @(posedge clock_in);
        reset_in <= 1'b0;
        @(negedge clock_in);
        chk(bank_out[63:0], 64'h0);
        t_write();
        for (int i = 0; i < 5; i++)
            for (int f = 0; f < 3; f++) t_div32(ns[i], ds[i], 2'(f));
        t_div64(64'h0123_4567_89AB_CDEF, 64'h0000_0001_0000_0003);
        t_prep(`FDIV_OP_SIGN_U32, 64'h0000_0009_5555_0000, 64'hFFFF_FFFE_0000_0007,
            64'h0000_0009_5555_0000, 64'hFFFF_FFFE_0000_0007, 1'b0);
        t_prep(`FDIV_OP_SIGN_S64_32, 64'hFFFF_FFFF_FFFF_FFF6, 64'hFFFF_FFFD_0000_0004,
            64'h0000_0000_0000_000A, 64'h0000_0003_0000_0004, 1'b0);
        t_prep(`FDIV_OP_SIGN_S64, 64'hFFFF_FFFF_FFFF_FFF9, 64'h0000_0000_0000_0002,
            64'h0000_0000_0000_0007, 64'h0000_0000_0000_0002, 1'b1);
        t_ovf();
        t_s16();
        finish_test();
    end
endmodule
`default_nettype wire
